// [hw/sync_ctl_pkg.sv]
package sync_ctl_pkg;
	// system clock and timing figures
	localparam int CLK_PERIOD_NS = 100;
	// longer composite pulses count as vertical
	localparam int VSEP_MIN_NS   = 10000;
	localparam int VSEP_CYCLES   = (VSEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// two-bit polarity select fields: high bit forces, low bit is the forced value
	localparam int POL_MANUAL_BIT = 1;
	localparam int POL_VALUE_BIT  = 0;
	// prevailing-level detector counters
	localparam int              DET_W     = 8;
	localparam logic [DET_W-1:0] DET_RESET = 8'h00;
	localparam logic [DET_W-1:0] DET_MAX   = 8'hff;
	localparam int DET_HS = 0;
	localparam int DET_VS = 1;
	localparam int DET_CL = 2;
	localparam int DET_CO = 3;
	// slicer threshold code n means (n+1) steps above the negative peak
	localparam int         THRESH_STEP_MV = 8;
	localparam int         THRESH_DEF_MV  = 128;
	localparam logic [4:0] THRESH_RESET   = 5'(THRESH_DEF_MV / THRESH_STEP_MV - 1);
	// reset values of control state
	localparam logic CLAMP_EXT_RESET = 1'b0;
	localparam logic COAST_POL_RESET = 1'b1;
	// edges to wait after reset before the address strap is caught
	localparam logic [3:0] STRAP_WAIT = 4'h4;
	// clamp window sequencer
	typedef enum logic [1:0] {
		CLAMP_IDLE  = 2'b00,
		CLAMP_DELAY = 2'b01,
		CLAMP_ON    = 2'b10
	} clamp_state_e;
	// sources for the slicer output pin
	typedef enum logic [1:0] {
		SLICE_RAW   = 2'b00,
		SLICE_HSYNC = 2'b01,
		SLICE_REGEN = 2'b10,
		SLICE_FILT  = 2'b11
	} slicer_src_e;
endpackage : sync_ctl_pkg

// [hw/hs_link_if.sv]
`timescale 1ns/1ps
interface hs_link_if #(parameter int WW = 8);
	logic          hs_toggle; // flips on each horizontal leading edge
	logic          hs_pol;    // regenerated hsync active level
	logic [WW-1:0] hs_width;  // regenerated hsync length in output clocks
	modport ctl (output hs_toggle, output hs_pol, output hs_width);
	modport link (input hs_toggle, input hs_pol, input hs_width);
endinterface : hs_link_if

// [hw/pixel_out_stage.sv]
`timescale 1ns/1ps
module pixel_out_stage #(
	parameter int PIX_W = 10,
	parameter int WW    = 8
) (
	input  wire logic             link_clk,
	input  wire logic             rst_n,
	hs_link_if.link               lk,
	input  wire logic [PIX_W-1:0] red_in,
	input  wire logic [PIX_W-1:0] green_in,
	input  wire logic [PIX_W-1:0] blue_in,
	output logic                  data_out_clock,
	output logic                  regen_hsync_out,
	output logic [PIX_W-1:0]      red_out,
	output logic [PIX_W-1:0]      green_out,
	output logic [PIX_W-1:0]      blue_out
);
	if (PIX_W < 1 || WW < 1) begin : g_chk
		$error("widths must be positive");
	end

	logic          rst_s1_reg, rst_s2_reg;           // reset brought into link domain
	logic          tog_s1_reg, tog_s2_reg, tog_s3_reg; // edge event crossing
	logic          pol_s1_reg, pol_s2_reg;           // quasi-static level crossing
	logic [WW-1:0] wid_s1_reg, wid_s2_reg;
	logic          dclk_reg, dclk_next;              // output clock, half link rate
	logic          pend_reg, pend_next;              // edge waiting for next update
	logic [WW-1:0] cnt_reg, cnt_next;                // remaining hsync length
	logic          hs_reg, hs_next;
	logic [PIX_W-1:0] r_reg, r_next, g_reg, g_next, b_reg, b_next;
	logic          edge_seen;

	// synchronisers; width and polarity are config, so bitwise sync is safe
	always_ff @(posedge link_clk) begin
		rst_s1_reg <= rst_n;
		rst_s2_reg <= rst_s1_reg;
		tog_s1_reg <= lk.hs_toggle;
		tog_s2_reg <= tog_s1_reg;
		tog_s3_reg <= tog_s2_reg;
		pol_s1_reg <= lk.hs_pol;
		pol_s2_reg <= pol_s1_reg;
		wid_s1_reg <= lk.hs_width;
		wid_s2_reg <= wid_s1_reg;
	end

	// the words and hsync change only as data_out_clock falls, keeping hsync aligned
	always_comb begin
		edge_seen = tog_s2_reg ^ tog_s3_reg;
		dclk_next = ~dclk_reg;
		pend_next = pend_reg | edge_seen;
		cnt_next  = cnt_reg;
		hs_next   = hs_reg;
		r_next    = r_reg;
		g_next    = g_reg;
		b_next    = b_reg;
		if (dclk_reg) begin // update slot
			r_next = red_in; // R14
			g_next = green_in;
			b_next = blue_in;
			pend_next = 1'b0;
			if (pend_reg || edge_seen) begin
				cnt_next = wid_s2_reg; // R21
			end else if (cnt_reg != '0) begin
				cnt_next = cnt_reg - WW'(1);
			end
			hs_next = (cnt_next != '0) ? pol_s2_reg : ~pol_s2_reg; // R15
		end
	end

	always_ff @(posedge link_clk) begin
		if (!rst_s2_reg) begin
			dclk_reg <= 1'b0;
			pend_reg <= 1'b0;
			cnt_reg  <= '0;
			hs_reg   <= 1'b0;
			r_reg    <= '0;
			g_reg    <= '0;
			b_reg    <= '0;
		end else begin
			dclk_reg <= dclk_next;
			pend_reg <= pend_next;
			cnt_reg  <= cnt_next;
			hs_reg   <= hs_next;
			r_reg    <= r_next;
			g_reg    <= g_next;
			b_reg    <= b_next;
		end
	end

	assign data_out_clock  = dclk_reg;
	assign regen_hsync_out = hs_reg;
	assign red_out         = r_reg;
	assign green_out       = g_reg;
	assign blue_out        = b_reg;
endmodule : pixel_out_stage

// [hw/sync_clamp_coast_control.sv]
`timescale 1ns/1ps
// Contract
// R1 - pll locks leading edge, clamp uses trailing
// R2 - hsync polarity auto or forced; 1 rising
// R3 - vsync drives field and coast; polarity selectable
// R4 - slicer threshold 8 mV steps, default 128
// R5 - composite slicer output separated into hsync
// R6 - external clamp only when enable bit set
// R7 - otherwise clamp window counted after trailing edge
// R8 - clamp pin polarity auto or forced
// R9 - source clamps only during back porch
// R10 - external clock select replaces loop clock
// R11 - coast freezes loop tracking of hsync
// R12 - coast polarity selectable, one after power-up
// R13 - power-down pin gated by select, polarity
// R14 - three ten-bit colour words, bit nine msb
// R15 - regenerated hsync aligned to output clock
// R16 - serial host clocks at most 100 kHz
// R17 - clock and coast share pin independently
// R18 - vsync output shares pin with address
// R19 - address pin sampled after reset as lsb
// R20 - slicer output picks one of four sources
// R21 - regenerated hsync polarity and width programmable
// R22 - auto polarity: opposite of prevailing level
module sync_clamp_coast_control #(
	parameter int PIX_W = 10,
	parameter int CW    = 8,
	parameter int LW    = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             link_clk,
	input  wire logic             hsync_in_a,
	input  wire logic             hsync_in_b,
	input  wire logic             vsync_in_a,
	input  wire logic             vsync_in_b,
	input  wire logic             embedded_sync_in_a,
	input  wire logic             embedded_sync_in_b,
	input  wire logic             clamp_in,
	input  wire logic             ext_clock_in,
	input  wire logic             power_down_pin,
	input  wire logic             addr_lsb_select,
	input  wire logic             input_sel,
	input  wire logic             hsync_src_embedded,
	input  wire logic [1:0]       hsync_pol_sel,
	input  wire logic [1:0]       vsync_pol_sel,
	input  wire logic [1:0]       clamp_pol_sel,
	input  wire logic [1:0]       coast_pol_sel,
	input  wire logic             clamp_ext_en,
	input  wire logic [CW-1:0]    clamp_delay,
	input  wire logic [CW-1:0]    clamp_width,
	input  wire logic             ext_clock_sel,
	input  wire logic             pd_select,
	input  wire logic             pd_polarity,
	input  wire logic             thresh_load,
	input  wire logic [4:0]       thresh_code,
	input  wire logic [1:0]       slicer_sel,
	input  wire logic             hs_out_pol,
	input  wire logic [7:0]       hs_out_width,
	input  wire logic [PIX_W-1:0] red_in,
	input  wire logic [PIX_W-1:0] green_in,
	input  wire logic [PIX_W-1:0] blue_in,
	output logic                  pll_ref_pulse,
	output logic                  clamp_out,
	output logic                  coast_out,
	output logic                  clock_sel_ext,
	output logic                  power_down,
	output logic                  slicer_out,
	output logic [4:0]            slicer_thresh,
	output logic                  field_odd,
	output logic                  regen_vsync_out,
	output logic                  regen_vsync_oe_n,
	output logic                  addr_lsb,
	output logic                  data_out_clock,
	output logic                  regen_hsync_out,
	output logic [PIX_W-1:0]      red_out,
	output logic [PIX_W-1:0]      green_out,
	output logic [PIX_W-1:0]      blue_out
);
	if (CW < 1 || LW < 2 || PIX_W < 1) begin : g_chk
		$error("counter widths too small");
	end

	localparam int NPIN = 10;
	localparam int NDET = 4;
	localparam logic [7:0] VSEP_MAX = 8'(sync_ctl_pkg::VSEP_CYCLES);

	// decide active level: forced value, or the opposite of what prevails
	function automatic logic resolve_pol(input logic [1:0] sel,
		input logic [sync_ctl_pkg::DET_W-1:0] c);
		if (sel[sync_ctl_pkg::POL_MANUAL_BIT]) begin
			return sel[sync_ctl_pkg::POL_VALUE_BIT];
		end
		return ~c[sync_ctl_pkg::DET_W-1]; // R22
	endfunction : resolve_pol

	// saturating up when high, down when low
	function automatic logic [sync_ctl_pkg::DET_W-1:0] det_step(
		input logic [sync_ctl_pkg::DET_W-1:0] c, input logic lvl);
		if (lvl && c != sync_ctl_pkg::DET_MAX) begin
			return c + sync_ctl_pkg::DET_W'(1);
		end
		if (!lvl && c != sync_ctl_pkg::DET_RESET) begin
			return c - sync_ctl_pkg::DET_W'(1);
		end
		return c;
	endfunction : det_step

	// ---- pin synchronisers: two flops before any logic looks at a pin
	logic [NPIN-1:0] pin_s1_reg, pin_s2_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end else begin
			pin_s1_reg <= {hsync_in_a, hsync_in_b, vsync_in_a, vsync_in_b,
				embedded_sync_in_a, embedded_sync_in_b, clamp_in,
				ext_clock_in, power_down_pin, addr_lsb_select};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	logic hs_a, hs_b, vs_a, vs_b, es_a, es_b, cl_pin, xc_pin, pd_pin, ad_pin;
	assign {hs_a, hs_b, vs_a, vs_b, es_a, es_b, cl_pin, xc_pin, pd_pin, ad_pin} =
		pin_s2_reg;

	// channel mux between the two input sets
	logic hs_raw, vs_raw, emb_raw;
	assign hs_raw  = input_sel ? hs_b : hs_a;
	assign vs_raw  = input_sel ? vs_b : vs_a;
	assign emb_raw = input_sel ? es_b : es_a;

	// ---- prevailing-level detectors for hsync, vsync, clamp and coast
	logic [sync_ctl_pkg::DET_W-1:0] det_reg  [NDET];
	logic [sync_ctl_pkg::DET_W-1:0] det_next [NDET];
	logic [NDET-1:0]                det_in;
	logic hs_sel_raw;
	logic hs_pol, vs_pol, cl_pol, co_pol;

	always_comb begin
		det_in[sync_ctl_pkg::DET_HS] = hs_sel_raw;
		det_in[sync_ctl_pkg::DET_VS] = vs_raw;
		det_in[sync_ctl_pkg::DET_CL] = cl_pin;
		det_in[sync_ctl_pkg::DET_CO] = xc_pin;
		for (int i = 0; i < NDET; i++) begin
			det_next[i] = det_step(det_reg[i], det_in[i]);
		end
	end

	// reset counters read as low-prevailing, so every input starts active high
	always_ff @(posedge clk) begin
		for (int i = 0; i < NDET; i++) begin
			if (!rst_n) begin
				det_reg[i] <= sync_ctl_pkg::DET_RESET;
			end else begin
				det_reg[i] <= det_next[i];
			end
		end
	end

	assign hs_pol = resolve_pol(hsync_pol_sel, det_reg[sync_ctl_pkg::DET_HS]); // R2
	assign vs_pol = resolve_pol(vsync_pol_sel, det_reg[sync_ctl_pkg::DET_VS]); // R3
	assign cl_pol = resolve_pol(clamp_pol_sel, det_reg[sync_ctl_pkg::DET_CL]); // R8
	assign co_pol = resolve_pol(coast_pol_sel, det_reg[sync_ctl_pkg::DET_CO]); // R12

	// ---- timing group: edges, clamp, coast, field, pins
	sync_ctl_pkg::clamp_state_e clamp_state_reg, clamp_state_next;
	logic [CW-1:0] clamp_cnt_reg, clamp_cnt_next;
	logic [7:0]    comp_run_reg, comp_run_next;   // composite pulse length
	logic [LW-1:0] line_cnt_reg, line_cnt_next;   // cycles since hsync lead
	logic [LW-1:0] line_len_reg, line_len_next;   // last full line length
	logic hs_prev_reg, hs_prev_next, vs_prev_reg, vs_prev_next;
	logic pll_ref_reg, pll_ref_next, clamp_reg, clamp_next;
	logic coast_reg, coast_next, clksel_reg, clksel_next;
	logic pd_reg, pd_next, slicer_reg, slicer_next;
	logic field_reg, field_next, vs_out_reg, vs_out_next;
	logic tog_reg, tog_next, oe_n_reg, oe_n_next, addr_reg, addr_next;
	logic hs_opol_reg, hs_opol_next;
	logic [7:0] hs_owid_reg, hs_owid_next;
	logic [4:0] thresh_reg, thresh_next;
	logic [3:0] strap_cnt_reg, strap_cnt_next;
	logic comp_act, comp_vert, sep_h, hs_act, vs_act, lead, trail, vs_lead, coast_act;

	always_comb begin
		// composite from the slicer: long pulses are vertical, drop them
		comp_act = ~(emb_raw ^ hs_pol);
		comp_run_next = comp_act ? ((comp_run_reg == VSEP_MAX) ? comp_run_reg
			: comp_run_reg + 8'h01) : 8'h00;
		comp_vert = (comp_run_reg == VSEP_MAX);
		sep_h = comp_vert ? ~hs_pol : emb_raw; // R5
		hs_sel_raw = hsync_src_embedded ? sep_h : hs_raw;
		hs_act  = ~(hs_sel_raw ^ hs_pol); // R2
		vs_act  = ~(vs_raw ^ vs_pol);
		lead    = hs_act & ~hs_prev_reg;
		trail   = ~hs_act & hs_prev_reg;
		vs_lead = vs_act & ~vs_prev_reg;
		hs_prev_next = hs_act;
		vs_prev_next = vs_act;
		// coast from the shared pin, or internally during vertical sync
		coast_act  = ~(xc_pin ^ co_pol) | vs_act; // R3 R11 R17
		coast_next = coast_act;
		pll_ref_next = lead & ~coast_act; // R1 R11
		clksel_next  = ext_clock_sel; // R10 R17
		pd_next      = pd_select & ~(pd_pin ^ pd_polarity); // R13
		thresh_next  = thresh_load ? thresh_code : thresh_reg; // R4
		tog_next     = tog_reg ^ lead; // R21
		hs_opol_next = hs_out_pol;
		hs_owid_next = hs_out_width;
		// clamp sequencer; only runs while the pin is not in charge
		clamp_state_next = clamp_state_reg;
		clamp_cnt_next   = clamp_cnt_reg;
		if (clamp_ext_en) begin // R6
			clamp_state_next = sync_ctl_pkg::CLAMP_IDLE;
			clamp_cnt_next   = '0;
		end else begin
			unique case (clamp_state_reg)
				sync_ctl_pkg::CLAMP_IDLE: begin
					if (trail) begin // R1 R7
						if (clamp_delay != '0) begin
							clamp_state_next = sync_ctl_pkg::CLAMP_DELAY;
							clamp_cnt_next   = clamp_delay;
						end else if (clamp_width != '0) begin
							clamp_state_next = sync_ctl_pkg::CLAMP_ON;
							clamp_cnt_next   = clamp_width;
						end
					end
				end
				sync_ctl_pkg::CLAMP_DELAY: begin
					if (clamp_cnt_reg == CW'(1)) begin
						clamp_state_next = (clamp_width != '0) ? sync_ctl_pkg::CLAMP_ON
							: sync_ctl_pkg::CLAMP_IDLE;
						clamp_cnt_next   = clamp_width;
					end else begin
						clamp_cnt_next = clamp_cnt_reg - CW'(1);
					end
				end
				sync_ctl_pkg::CLAMP_ON: begin
					if (clamp_cnt_reg == CW'(1)) begin
						clamp_state_next = sync_ctl_pkg::CLAMP_IDLE;
					end
					clamp_cnt_next = clamp_cnt_reg - CW'(1);
				end
				default: begin // the unused code falls back to idle
					clamp_state_next = sync_ctl_pkg::CLAMP_IDLE;
				end
			endcase
		end
		// pin ignored unless enabled; else the counted window
		clamp_next = clamp_ext_en ? ~(cl_pin ^ cl_pol)
			: (clamp_state_next == sync_ctl_pkg::CLAMP_ON); // R6 R7 R8
		// field: vertical edge in the first half of a line means odd
		line_cnt_next = lead ? '0 : ((&line_cnt_reg) ? line_cnt_reg
			: line_cnt_reg + LW'(1));
		line_len_next = lead ? line_cnt_reg : line_len_reg;
		field_next    = vs_lead ? (line_cnt_reg < (line_len_reg >> 1)) : field_reg;
		vs_out_next   = vs_act; // R18
		// slicer pin source
		unique case (sync_ctl_pkg::slicer_src_e'(slicer_sel)) // R20
			sync_ctl_pkg::SLICE_RAW:   slicer_next = emb_raw;
			sync_ctl_pkg::SLICE_HSYNC: slicer_next = hs_raw;
			sync_ctl_pkg::SLICE_REGEN: slicer_next = hs_act;
			sync_ctl_pkg::SLICE_FILT:  slicer_next = sep_h;
		endcase
		// strap: pin left undriven after reset, caught, then driven
		strap_cnt_next = strap_cnt_reg;
		addr_next      = addr_reg;
		oe_n_next      = oe_n_reg;
		if (strap_cnt_reg != sync_ctl_pkg::STRAP_WAIT) begin
			strap_cnt_next = strap_cnt_reg + 4'h1;
		end else if (oe_n_reg) begin
			addr_next = ad_pin; // R19
			oe_n_next = 1'b0;   // R18
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clamp_state_reg <= sync_ctl_pkg::CLAMP_IDLE;
			clamp_cnt_reg   <= '0;
			comp_run_reg    <= 8'h00;
			line_cnt_reg    <= '0;
			line_len_reg    <= '0;
			hs_prev_reg     <= 1'b0;
			vs_prev_reg     <= 1'b0;
			pll_ref_reg     <= 1'b0;
			clamp_reg       <= sync_ctl_pkg::CLAMP_EXT_RESET;
			coast_reg       <= 1'b0;
			clksel_reg      <= 1'b0;
			pd_reg          <= 1'b0;
			slicer_reg      <= 1'b0;
			field_reg       <= 1'b0;
			vs_out_reg      <= 1'b0;
			tog_reg         <= 1'b0;
			oe_n_reg        <= 1'b1;
			addr_reg        <= 1'b0;
			hs_opol_reg     <= 1'b0;
			hs_owid_reg     <= 8'h00;
			thresh_reg      <= sync_ctl_pkg::THRESH_RESET; // R4
			strap_cnt_reg   <= 4'h0;
		end else begin
			clamp_state_reg <= clamp_state_next;
			clamp_cnt_reg   <= clamp_cnt_next;
			comp_run_reg    <= comp_run_next;
			line_cnt_reg    <= line_cnt_next;
			line_len_reg    <= line_len_next;
			hs_prev_reg     <= hs_prev_next;
			vs_prev_reg     <= vs_prev_next;
			pll_ref_reg     <= pll_ref_next;
			clamp_reg       <= clamp_next;
			coast_reg       <= coast_next;
			clksel_reg      <= clksel_next;
			pd_reg          <= pd_next;
			slicer_reg      <= slicer_next;
			field_reg       <= field_next;
			vs_out_reg      <= vs_out_next;
			tog_reg         <= tog_next;
			oe_n_reg        <= oe_n_next;
			addr_reg        <= addr_next;
			hs_opol_reg     <= hs_opol_next;
			hs_owid_reg     <= hs_owid_next;
			thresh_reg      <= thresh_next;
			strap_cnt_reg   <= strap_cnt_next;
		end
	end

	// ---- link domain: words, output clock and regenerated hsync
	hs_link_if #(.WW(8)) lk ();
	assign lk.hs_toggle = tog_reg;
	assign lk.hs_pol    = hs_opol_reg;
	assign lk.hs_width  = hs_owid_reg;

	pixel_out_stage #(.PIX_W(PIX_W), .WW(8)) u_out (
		.link_clk        (link_clk),
		.rst_n           (rst_n),
		.lk              (lk.link),
		.red_in          (red_in),
		.green_in        (green_in),
		.blue_in         (blue_in),
		.data_out_clock  (data_out_clock),
		.regen_hsync_out (regen_hsync_out),
		.red_out         (red_out),
		.green_out       (green_out),
		.blue_out        (blue_out)
	);

	assign pll_ref_pulse    = pll_ref_reg;
	assign clamp_out        = clamp_reg;
	assign coast_out        = coast_reg;
	assign clock_sel_ext    = clksel_reg;
	assign power_down       = pd_reg;
	assign slicer_out       = slicer_reg;
	assign slicer_thresh    = thresh_reg;
	assign field_odd        = field_reg;
	assign regen_vsync_out  = vs_out_reg;
	assign regen_vsync_oe_n = oe_n_reg;
	assign addr_lsb         = addr_reg;
endmodule : sync_clamp_coast_control

// [sim/sync_src_model.sv]
`timescale 1ns/1ps
// far-side source: line timing, composite sync, back-porch clamp
module sync_src_model #(
	parameter int LINE = 40, // line length in clk cycles
	parameter int HW   = 8   // hsync pulse length in clk cycles
) (
	input  wire logic clk,
	input  wire logic hs_neg, // 1 sends an active-low hsync
	output logic      hs,     // separate hsync pin
	output logic      es,     // sliced composite, dips low in sync
	output logic      cl      // external clamp pulse
);
	int cnt = 0; // position within the line
	initial {hs, es, cl} = 3'b010;
	// change just after the edge, never at it
	always @(posedge clk) begin
		#1;
		cnt = (cnt + 1) % LINE;
		hs = (cnt < HW) ^ hs_neg;
		es = !(cnt < HW);
		cl = (cnt >= HW + 2) && (cnt < HW + 6);
	end
endmodule : sync_src_model

// [sim/sync_clamp_coast_control_chk.sv]
`timescale 1ns/1ps
// sees the block's pins only
module sync_clamp_coast_control_chk #(
	parameter int CW = 8 // clamp count width
) (
	input wire logic          clk,
	input wire logic          rst_n,
	input wire logic          link_clk,
	input wire logic          ext_clock_sel,
	input wire logic          thresh_load,
	input wire logic [4:0]    thresh_code,
	input wire logic          pd_select,
	input wire logic          pd_polarity,
	input wire logic          power_down_pin,
	input wire logic          clamp_ext_en,
	input wire logic [CW-1:0] clamp_width,
	input wire logic          pll_ref_pulse,
	input wire logic          clamp_out,
	input wire logic          coast_out,
	input wire logic          clock_sel_ext,
	input wire logic          power_down,
	input wire logic [4:0]    slicer_thresh,
	input wire logic          regen_vsync_oe_n,
	input wire logic          addr_lsb,
	input wire logic          data_out_clock,
	input wire logic          regen_hsync_out
);
	property p_sel_ext;
		@(posedge clk) disable iff (!rst_n) $rose(ext_clock_sel) |-> ##[1:4] clock_sel_ext;
	endproperty
	a_sel_ext: assert property (p_sel_ext) else $error("clock select flag late");
	property p_thresh;
		@(posedge clk) disable iff (!rst_n) thresh_load |=> slicer_thresh == $past(thresh_code);
	endproperty
	a_thresh: assert property (p_thresh) else $error("threshold not loaded");
	property p_ref_one;
		@(posedge clk) disable iff (!rst_n) pll_ref_pulse |=> !pll_ref_pulse;
	endproperty
	a_ref_one: assert property (p_ref_one) else $error("loop pulse too long");
	// a held coast must have silenced the loop reference
	property p_coast;
		@(posedge clk) disable iff (!rst_n) coast_out [*4] |-> !pll_ref_pulse;
	endproperty
	a_coast: assert property (p_coast) else $error("loop pulse while coasting");
	property p_pd_off;
		@(posedge clk) disable iff (!rst_n) !pd_select [*5] |-> !power_down;
	endproperty
	a_pd_off: assert property (p_pd_off) else $error("power down unselected");
	property p_pd_on;
		@(posedge clk) disable iff (!rst_n)
			(pd_select && pd_polarity && power_down_pin) [*5] |-> power_down;
	endproperty
	a_pd_on: assert property (p_pd_on) else $error("power down missed");
	// once caught, the strap holds and the pin drives
	property p_strap;
		@(posedge clk) disable iff (!rst_n)
			!regen_vsync_oe_n |=> !regen_vsync_oe_n && $stable(addr_lsb);
	endproperty
	a_strap: assert property (p_strap) else $error("strap changed");
	property p_clamp_one;
		@(posedge clk) disable iff (!rst_n)
			$rose(clamp_out) && !clamp_ext_en && clamp_width == CW'(1) |=> !clamp_out;
	endproperty
	a_clamp_one: assert property (p_clamp_one) else $error("clamp window length");
	property p_hs_align;
		@(posedge link_clk) disable iff (!rst_n) $changed(regen_hsync_out) |-> $fell(data_out_clock);
	endproperty
	a_hs_align: assert property (p_hs_align) else $error("hsync off output clock");
endmodule : sync_clamp_coast_control_chk
bind sync_clamp_coast_control sync_clamp_coast_control_chk #(.CW(CW)) u_chk (
	.clk, .rst_n, .link_clk, .ext_clock_sel, .thresh_load, .thresh_code, .pd_select,
	.pd_polarity, .power_down_pin, .clamp_ext_en, .clamp_width, .pll_ref_pulse, .clamp_out,
	.coast_out, .clock_sel_ext, .power_down, .slicer_thresh, .regen_vsync_oe_n, .addr_lsb,
	.data_out_clock, .regen_hsync_out);

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic clk = 0, link_clk = 0, rst_n = 0, hs_neg = 0, vs_pin = 0; // clocks, reset, source
	logic ext_clock_in = 0, power_down_pin = 0, addr_lsb_select = 1, ext_clock_sel = 0;
	logic pd_select = 0, pd_polarity = 1, thresh_load = 0, clamp_ext_en = 0, hs_out_pol = 1;
	logic [1:0] hsync_pol_sel = 2'b11, clamp_pol_sel = 2'b11, coast_pol_sel = 2'b11;
	logic [1:0] slicer_sel = 0;
	logic [4:0] thresh_code = 0, slicer_thresh;
	logic [7:0] clamp_delay = 0, clamp_width = 1, hs_out_width = 8'h04;
	logic [9:0] pix = 10'h2a5, red_out, green_out, blue_out;
	logic pll_ref_pulse, clamp_out, coast_out, clock_sel_ext, power_down, slicer_out;
	logic field_odd, regen_vsync_out, regen_vsync_oe_n, addr_lsb, data_out_clock;
	logic regen_hsync_out, hs, es, cl;
	int fail_count = 0, n_checks = 0, cyc = 0, n, m; // tallies, scratch
	logic [3:0] pd_tab [4] = '{4'b1111, 4'b1100, 4'b1001, 4'b0110}; // sel pol pin expect
	sync_src_model u_src (.clk, .hs_neg, .hs, .es, .cl);
	sync_clamp_coast_control u_dut (.clk, .rst_n, .link_clk, .hsync_in_a(hs), .hsync_in_b(hs),
		.vsync_in_a(vs_pin), .vsync_in_b(vs_pin), .embedded_sync_in_a(es),
		.embedded_sync_in_b(es), .clamp_in(cl), .ext_clock_in, .power_down_pin,
		.addr_lsb_select, .input_sel(1'b0), .hsync_src_embedded(1'b0), .hsync_pol_sel,
		.vsync_pol_sel(2'b00), .clamp_pol_sel, .coast_pol_sel, .clamp_ext_en, .clamp_delay,
		.clamp_width, .ext_clock_sel, .pd_select, .pd_polarity, .thresh_load, .thresh_code,
		.slicer_sel, .hs_out_pol, .hs_out_width, .red_in(pix), .green_in(~pix),
		.blue_in(pix), .pll_ref_pulse, .clamp_out, .coast_out, .clock_sel_ext, .power_down,
		.slicer_out, .slicer_thresh, .field_odd, .regen_vsync_out, .regen_vsync_oe_n,
		.addr_lsb, .data_out_clock, .regen_hsync_out, .red_out, .green_out, .blue_out);
	always #50 clk = ~clk;
	always #40 link_clk = ~link_clk; // unrelated link rate
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			fail_count++;
			$display("wrong value at %0t: run timed out", $time);
			wrap_up();
		end
	end
	task ck(input logic ok, input string what);
		n_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : ck
	task tick; // just after the rising edge
		@(posedge clk);
		#1;
	endtask : tick
	function automatic logic sig(input int w);
		case (w)
			0: return pll_ref_pulse;
			1: return clamp_out;
			2: return hs;
			default: return cl;
		endcase
	endfunction : sig
	task automatic edge_at(input int w, input logic lvl); // stop where lvl is first seen
		@(negedge clk);
		while (sig(w) === lvl) @(negedge clk);
		while (sig(w) !== lvl) @(negedge clk);
	endtask : edge_at
	task automatic rise_in(input int w, output int k); // cycles to high
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (sig(w) !== 1'b1 && k < 60);
	endtask : rise_in
	task automatic high_len(input int w, output int k);
		k = 0;
		while (sig(w) === 1'b1) begin
			@(negedge clk);
			k++;
		end
	endtask : high_len
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (3) @(negedge clk);
		ck(slicer_thresh === 5'h0f && regen_vsync_oe_n === 1'b1, "reset state");
		tick();
		rst_n = 1;
		repeat (8) @(negedge clk);
		ck(addr_lsb === 1'b1 && regen_vsync_oe_n === 1'b0, "strap caught");
		tick();
		addr_lsb_select = 0;
		repeat (6) @(negedge clk);
		ck(addr_lsb === 1'b1, "strap held");
		for (int i = 0; i < 2; i++) begin
			tick();
			thresh_code = 5'(-i);
			thresh_load = 1;
			tick();
			thresh_load = 0;
			@(negedge clk);
			ck(slicer_thresh === thresh_code, "threshold code");
		end
		$display("test reset and threshold done");
		// forced rising, forced falling, then auto on an active-low source
		for (int i = 0; i < 3; i++) begin
			tick();
			hsync_pol_sel = 2'(3 - i);
			hs_neg = i == 2;
			repeat (400) @(negedge clk);
			edge_at(2, i == 0);
			rise_in(0, n);
			ck(n == 3, "loop edge timing");
		end
		tick();
		hsync_pol_sel = 2'b11;
		hs_neg = 0;
		ext_clock_in = 1;
		ext_clock_sel = 1;
		repeat (6) @(negedge clk);
		ck(coast_out === 1'b1 && clock_sel_ext === 1'b1, "coast and clock");
		rise_in(0, m);
		ck(m == 60, "coast holds loop");
		tick();
		ext_clock_in = 0;
		repeat (6) @(negedge clk);
		ck(coast_out === 1'b0 && clock_sel_ext === 1'b1, "coast off");
		$display("test sync and coast done");
		for (int i = 0; i < 2; i++) begin
			edge_at(2, 1);
			tick();
			clamp_delay = i ? 8'h05 : 8'h00;
			clamp_width = i ? 8'h03 : 8'h01;
			edge_at(2, 0);
			rise_in(1, n);
			ck(n == 3 + clamp_delay, "clamp delay");
			high_len(1, m);
			ck(m == clamp_width, "clamp width");
		end
		tick();
		clamp_ext_en = 1;
		repeat (50) @(negedge clk);
		edge_at(3, 1);
		rise_in(1, n);
		high_len(1, m);
		ck(n == 3 && m == 4, "external clamp");
		tick();
		clamp_pol_sel = 2'b10;
		repeat (50) @(negedge clk);
		edge_at(2, 1);
		ck(clamp_out === 1'b1, "clamp active low");
		tick();
		clamp_ext_en = 0;
		clamp_pol_sel = 2'b11;
		$display("test clamp done");
		foreach (pd_tab[i]) begin
			tick();
			{pd_select, pd_polarity, power_down_pin} = pd_tab[i][3:1];
			repeat (6) @(negedge clk);
			ck(power_down === pd_tab[i][0], "power down");
		end
		for (int s = 0; s < 4; s++) begin
			tick();
			slicer_sel = 2'(s);
			edge_at(2, 1);
			repeat (5) @(negedge clk);
			ck(slicer_out === (s == 1 || s == 2), "slicer source");
		end
		$display("test power and slicer done");
		ck(red_out === pix && green_out === ~pix && blue_out === pix, "pixel words");
		@(posedge regen_hsync_out);
		m = 0;
		@(negedge link_clk);
		while (regen_hsync_out === 1'b1) begin
			@(negedge link_clk);
			m++;
		end
		ck(m == 2 * hs_out_width, "hsync out width");
		tick();
		hs_out_pol = 0;
		edge_at(2, 0);
		repeat (20) @(negedge clk);
		ck(regen_hsync_out === 1'b1, "hsync out polarity");
		$display("test link done");
		wrap_up();
	end
endmodule : testbench
